// >>> include/slt_defines.svh
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define SLT_IDX_PIN_POL     10'h1E4
`define SLT_IDX_PAT_CTRL    10'h1E5
`define SLT_IDX_REPEAT      10'h1E6
`define SLT_IDX_SYNC_SYSREF 10'h1E7
`define SLT_IDX_ALIGN_CTRL  10'h1F0
`define SLT_IDX_USER_LO     10'h1F1
`define SLT_IDX_USER_HI     10'h1F2
`define SLT_IDX_STATUS      10'h1F3

// ==========================================================================
// Field positions
`define SLT_POL_INV_BIT     5
`define SLT_SYM_INV_BIT     1
`define SLT_SEL_MSB         5
`define SLT_SEL_LSB         4
`define SLT_MODE_MSB        3
`define SLT_MODE_LSB        0
`define SLT_SYSREF_PD_BIT   3
`define SLT_SYNC_DIFF_BIT   2
`define SLT_DELAY_MSB       7
`define SLT_DELAY_LSB       4
`define SLT_AMODE_MSB       3
`define SLT_AMODE_LSB       2

// ==========================================================================
// Reset values and pattern constants
`define SLT_RST_REG         8'h00
`define SLT_RST_ALIGN_CTRL  8'h04
`define SLT_PN23_SEED       23'h7FFFFF
`define SLT_PN9_SEED        9'h1FF
`define SLT_CHECKER_WORD    16'hAAAA
`define SLT_JPAT_SEED       16'hBE07

`endif

// >>> include/slt_pkg.sv
// ==========================================================================
// Types shared by the link control block
package slt_pkg;

  typedef enum logic [3:0] {
    SLT_TM_OFF      = 4'h0,
    SLT_TM_CHECKER  = 4'h1,
    SLT_TM_TOGGLE   = 4'h2,
    SLT_TM_PN_LONG  = 4'h3,
    SLT_TM_PN_SHORT = 4'h4,
    SLT_TM_USER_REP = 4'h5,
    SLT_TM_USER_ONE = 4'h6,
    SLT_TM_RAMP     = 4'h7,
    SLT_TM_RPAT     = 4'h8,
    SLT_TM_UNUSED   = 4'h9,
    SLT_TM_JSPAT    = 4'hA,
    SLT_TM_JTSPAT   = 4'hB
  } slt_test_mode_type;

  typedef enum logic [1:0] {
    SLT_INS_FRAMER    = 2'h0,
    SLT_INS_PHY       = 2'h1,
    SLT_INS_SCRAMBLER = 2'h2
  } slt_insert_type;

  typedef enum logic [2:0] {
    SLT_LS_SYNC  = 3'h0,
    SLT_LS_WAIT  = 3'h1,
    SLT_LS_DELAY = 3'h2,
    SLT_LS_ALIGN = 3'h3,
    SLT_LS_DATA  = 3'h4
  } slt_link_state_type;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } slt_sample_type;

  typedef struct packed {
    logic [7:0] pin_pol;
    logic [7:0] pat_ctrl;
    logic [7:0] repeat_cnt;
    logic [7:0] sync_sysref;
    logic [7:0] align_ctrl;
    logic [7:0] user_lo;
    logic [7:0] user_hi;
  } slt_regs_type;

  typedef struct packed {
    slt_regs_type       regs;
    logic               ack;
    logic [31:0]        dat;
    slt_link_state_type link_state;
    logic [3:0]         delay_cnt;
    logic [7:0]         ilas_cnt;
    logic [22:0]        pn_long;
    logic [8:0]         pn_short;
    logic [15:0]        ramp;
    logic               toggle;
    logic               single_done;
    logic [2:0]         pat_idx;
    logic               sync_asserted;
    logic               sysref_event;
    logic               ilas_active;
    slt_sample_type     framer;
    logic [7:0]         octet;
    logic [9:0]         symbol;
  } slt_state_type;

endpackage : slt_pkg

// >>> core/slt_link_ctrl.sv
// Summary of operation
// - Sync request counts as asserted when low, or when high once the polarity bit is set.
// - With symbol inversion set, every bit of each 10-bit symbol is inverted on its way out.
// - The insertion select puts test data at the framer (00), PHY (01) or scrambler (10) input.
// - Mode codes give off, checkerboard, word toggle, long PN, short PN, RPAT, JSPAT, JTSPAT.
// - Mode 0101 repeats the user word and mode 0110 sends it only once.
// - Mode 0111 is a ramp, and in single-lane use Q equals I minus one.
// - The alignment sequence is sent repeat count plus one multiframes.
// - SYSREF receiver power-down hides all SYSREF pulses.
// - The sync input select picks the single-ended receiver at 0 and the differential at 1.
// - Alignment starts on the first multiframe edge after sync release, plus a delay.
// - Alignment mode 01 runs one alignment phase, mode 11 runs it without end.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "slt_defines.svh"

module slt_link_ctrl
  import slt_pkg::*;
(
  input  wire logic           CLOCK,
  input  wire logic           RST,
  input  wire logic           WB_CYC_I,
  input  wire logic           WB_STB_I,
  input  wire logic           WB_WE_I,
  input  wire logic [11:0]    WB_ADR_I,
  input  wire logic [3:0]     WB_SEL_I,
  input  wire logic [31:0]    WB_DAT_I,
  output logic      [31:0]    WB_DAT_O,
  output logic                WB_ACK_O,
  input  wire logic           SYNC_REQ_CMOS,
  input  wire logic           SYNC_REQ_DIFF,
  input  wire logic           SYSREF_IN,
  input  wire logic           LMFC_EDGE,
  input  wire logic           SINGLE_LANE,
  input  wire slt_sample_type SAMPLE_IN,
  input  wire logic [7:0]     OCTET_IN,
  input  wire logic [9:0]     SYMBOL_IN,
  output slt_sample_type      FRAMER_OUT,
  output logic      [7:0]     OCTET_OUT,
  output logic      [9:0]     SYMBOL_OUT,
  output logic                SYNC_ASSERTED,
  output logic                SYNC_DIFF_SELECT,
  output logic                SYSREF_RX_POWERDOWN,
  output logic                SYSREF_EVENT,
  output logic                ILAS_ACTIVE
);

  // ========================================================================
  // State and decoded fields
  slt_state_type     s;
  slt_state_type     next_s;
  slt_test_mode_type mode;
  slt_insert_type    ins_sel;
  logic [9:0]        reg_idx;
  logic [7:0]        rd_byte;
  logic              test_on;
  logic              sync_line;
  logic [15:0]       gen_i;
  logic [15:0]       gen_q;
  logic [15:0]       jpat;
  logic [15:0]       user_word;
  logic [9:0]        sym_pre;
  logic [3:0]        align_delay;
  logic [1:0]        align_mode;

  // PN generators advance sixteen bits per clock to fill one word
  function automatic logic [22:0] slt_pn23_step(input logic [22:0] v);
    logic [22:0] r;
    r = v;
    for (int k = 0; k < 16; k++) begin
      r = {r[21:0], r[22] ^ r[17]};
    end
    return r;
  endfunction : slt_pn23_step

  function automatic logic [8:0] slt_pn9_step(input logic [8:0] v);
    logic [8:0] r;
    r = v;
    for (int k = 0; k < 16; k++) begin
      r = {r[7:0], r[8] ^ r[4]};
    end
    return r;
  endfunction : slt_pn9_step

  // Field decode; codes 11 of the select and 1001/11xx of the mode leave data alone
  assign mode        = slt_test_mode_type'(s.regs.pat_ctrl[`SLT_MODE_MSB:`SLT_MODE_LSB]);
  assign ins_sel     = slt_insert_type'(s.regs.pat_ctrl[`SLT_SEL_MSB:`SLT_SEL_LSB]);
  assign align_delay = s.regs.align_ctrl[`SLT_DELAY_MSB:`SLT_DELAY_LSB];
  assign align_mode  = s.regs.align_ctrl[`SLT_AMODE_MSB:`SLT_AMODE_LSB];
  assign user_word   = {s.regs.user_hi, s.regs.user_lo};
  assign reg_idx     = WB_ADR_I[11:2];
  assign test_on     = (mode != SLT_TM_OFF) && (mode != SLT_TM_UNUSED) && (mode <= SLT_TM_JTSPAT);

  // Receiver choice, then polarity
  assign sync_line = s.regs.sync_sysref[`SLT_SYNC_DIFF_BIT] ? SYNC_REQ_DIFF : SYNC_REQ_CMOS;

  // ========================================================================
  // Register read mux; unmapped indices read as zero
  always_comb begin
    case (reg_idx)
      `SLT_IDX_PIN_POL:     rd_byte = s.regs.pin_pol;
      `SLT_IDX_PAT_CTRL:    rd_byte = s.regs.pat_ctrl;
      `SLT_IDX_REPEAT:      rd_byte = s.regs.repeat_cnt;
      `SLT_IDX_SYNC_SYSREF: rd_byte = s.regs.sync_sysref;
      `SLT_IDX_ALIGN_CTRL:  rd_byte = s.regs.align_ctrl;
      `SLT_IDX_USER_LO:     rd_byte = s.regs.user_lo;
      `SLT_IDX_USER_HI:     rd_byte = s.regs.user_hi;
      `SLT_IDX_STATUS:      rd_byte = {1'b0, s.link_state, s.ilas_active, s.sync_asserted,
                                       s.single_done, 1'b0};
      default:              rd_byte = 8'h00;
    endcase
  end

  // ========================================================================
  // Pattern words; the JESD-style fills are a rotating seed, not exact sequences
  always_comb begin
    jpat = (`SLT_JPAT_SEED << s.pat_idx) | (`SLT_JPAT_SEED >> (5'd16 - {2'b00, s.pat_idx}));
    case (mode)
      SLT_TM_CHECKER:  gen_i = s.toggle ? `SLT_CHECKER_WORD : ~`SLT_CHECKER_WORD;
      SLT_TM_TOGGLE:   gen_i = s.toggle ? 16'hFFFF : 16'h0000;
      SLT_TM_PN_LONG:  gen_i = s.pn_long[15:0];
      SLT_TM_PN_SHORT: gen_i = {s.pn_short[6:0], s.pn_short};
      SLT_TM_USER_REP: gen_i = user_word;
      SLT_TM_USER_ONE: gen_i = s.single_done ? 16'h0000 : user_word;
      SLT_TM_RAMP:     gen_i = s.ramp;
      SLT_TM_RPAT:     gen_i = jpat;
      SLT_TM_JSPAT:    gen_i = s.pat_idx[0] ? ~jpat : jpat;
      SLT_TM_JTSPAT:   gen_i = jpat ^ 16'h00FF;
      default:         gen_i = 16'h0000;
    endcase
    // Only the ramp separates I and Q
    if (mode == SLT_TM_RAMP && SINGLE_LANE) begin
      gen_q = s.ramp - 16'h0001;
    end else begin
      gen_q = gen_i;
    end
  end

  // ========================================================================
  // Next-state logic for bus, generators, datapath and alignment sequencer
  always_comb begin
    next_s = s;

    // Bus answer one cycle after the request; write lands on the acked edge
    next_s.ack = WB_CYC_I && WB_STB_I && !s.ack;
    if (WB_CYC_I && WB_STB_I && !s.ack) begin
      next_s.dat = {24'h000000, rd_byte};
    end
    if (WB_CYC_I && WB_STB_I && s.ack && WB_WE_I && WB_SEL_I[0]) begin
      case (reg_idx)
        `SLT_IDX_PIN_POL:     next_s.regs.pin_pol     = WB_DAT_I[7:0];
        `SLT_IDX_PAT_CTRL: begin
          next_s.regs.pat_ctrl = WB_DAT_I[7:0];
          next_s.single_done   = 1'b0;
        end
        `SLT_IDX_REPEAT:      next_s.regs.repeat_cnt  = WB_DAT_I[7:0];
        `SLT_IDX_SYNC_SYSREF: next_s.regs.sync_sysref = WB_DAT_I[7:0];
        `SLT_IDX_ALIGN_CTRL:  next_s.regs.align_ctrl  = WB_DAT_I[7:0];
        `SLT_IDX_USER_LO:     next_s.regs.user_lo     = WB_DAT_I[7:0];
        `SLT_IDX_USER_HI:     next_s.regs.user_hi     = WB_DAT_I[7:0];
        default:              next_s.regs = s.regs;
      endcase
    end

    // Generators run only while testing, so a test entered from mode off starts from the seed
    if (test_on) begin
      next_s.toggle   = !s.toggle;
      next_s.pn_long  = slt_pn23_step(s.pn_long);
      next_s.pn_short = slt_pn9_step(s.pn_short);
      next_s.ramp     = s.ramp + 16'h0001;
      next_s.pat_idx  = s.pat_idx + 3'h1;
    end else begin
      next_s.toggle   = 1'b0;
      next_s.pn_long  = `SLT_PN23_SEED;
      next_s.pn_short = `SLT_PN9_SEED;
      next_s.ramp     = 16'h0000;
      next_s.pat_idx  = 3'h0;
    end
    // Set after the write clear, so a word already sent is never forgotten
    if (mode == SLT_TM_USER_ONE) begin
      next_s.single_done = 1'b1;
    end

    // Substitute only at the chosen point; later stages pass their input
    if (test_on && ins_sel == SLT_INS_FRAMER) begin
      next_s.framer = '{i: gen_i, q: gen_q};
    end else begin
      next_s.framer = SAMPLE_IN;
    end
    next_s.octet = (test_on && ins_sel == SLT_INS_SCRAMBLER) ? gen_i[7:0] : OCTET_IN;
    sym_pre      = (test_on && ins_sel == SLT_INS_PHY) ? gen_i[9:0] : SYMBOL_IN;
    next_s.symbol = s.regs.pin_pol[`SLT_SYM_INV_BIT] ? ~sym_pre : sym_pre;

    // Sync level and SYSREF gate
    next_s.sync_asserted = s.regs.pin_pol[`SLT_POL_INV_BIT] ? sync_line : !sync_line;
    next_s.sysref_event  = SYSREF_IN && !s.regs.sync_sysref[`SLT_SYSREF_PD_BIT];

    // Alignment sequencer, paced by multiframe edges
    case (s.link_state)
      SLT_LS_SYNC: begin
        next_s.ilas_active = 1'b0;
        if (!s.sync_asserted) begin
          next_s.link_state = SLT_LS_WAIT;
        end
      end
      SLT_LS_WAIT: begin
        if (LMFC_EDGE) begin
          if (align_delay == 4'h0) begin
            next_s.link_state  = (align_mode[0]) ? SLT_LS_ALIGN : SLT_LS_DATA;
            next_s.ilas_active = align_mode[0];
            next_s.ilas_cnt    = 8'h00;
          end else begin
            next_s.delay_cnt  = align_delay;
            next_s.link_state = SLT_LS_DELAY;
          end
        end
      end
      SLT_LS_DELAY: begin
        if (LMFC_EDGE) begin
          next_s.delay_cnt = s.delay_cnt - 4'h1;
          if (s.delay_cnt == 4'h1) begin
            next_s.link_state  = (align_mode[0]) ? SLT_LS_ALIGN : SLT_LS_DATA;
            next_s.ilas_active = align_mode[0];
            next_s.ilas_cnt    = 8'h00;
          end
        end
      end
      SLT_LS_ALIGN: begin
        // Continuous mode leaves only on a sync request; useful as a link-layer soak
        if (LMFC_EDGE && align_mode != 2'b11) begin
          if (s.ilas_cnt == s.regs.repeat_cnt) begin
            next_s.link_state  = SLT_LS_DATA;
            next_s.ilas_active = 1'b0;
          end else begin
            next_s.ilas_cnt = s.ilas_cnt + 8'h01;
          end
        end
      end
      SLT_LS_DATA: next_s.ilas_active = 1'b0;
      default: begin
        next_s.link_state  = SLT_LS_SYNC;
        next_s.ilas_active = 1'b0;
      end
    endcase
    // A fresh sync request aborts whatever the link was doing
    if (s.sync_asserted) begin
      next_s.link_state  = SLT_LS_SYNC;
      next_s.ilas_active = 1'b0;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s                 <= '0;
      s.regs.align_ctrl <= `SLT_RST_ALIGN_CTRL;
      s.pn_long         <= `SLT_PN23_SEED;
      s.pn_short        <= `SLT_PN9_SEED;
      s.link_state      <= SLT_LS_SYNC;
    end else begin
      s <= next_s;
    end
  end

  // Outputs are state fields
  assign WB_DAT_O            = s.dat;
  assign WB_ACK_O            = s.ack;
  assign FRAMER_OUT          = s.framer;
  assign OCTET_OUT           = s.octet;
  assign SYMBOL_OUT          = s.symbol;
  assign SYNC_ASSERTED       = s.sync_asserted;
  assign SYNC_DIFF_SELECT    = s.regs.sync_sysref[`SLT_SYNC_DIFF_BIT];
  assign SYSREF_RX_POWERDOWN = s.regs.sync_sysref[`SLT_SYSREF_PD_BIT];
  assign SYSREF_EVENT        = s.sysref_event;
  assign ILAS_ACTIVE         = s.ilas_active;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // Sampled reset in the antecedent skips the edge that releases reset
  property p_sync_level;
    !RST |=> SYNC_ASSERTED == ($past(s.regs.pin_pol[`SLT_POL_INV_BIT]) ?
      $past(sync_line) : !$past(sync_line));
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("sync level wrong");

  property p_sym_inv;
    !RST && !(test_on && ins_sel == SLT_INS_PHY) |=> SYMBOL_OUT ==
      ($past(s.regs.pin_pol[`SLT_SYM_INV_BIT]) ? ~$past(SYMBOL_IN) : $past(SYMBOL_IN));
  endproperty
  a_sym_inv: assert property (p_sym_inv) else $error("symbol inversion wrong");

  property p_scr_point;
    (test_on && ins_sel == SLT_INS_SCRAMBLER) |=>
      (OCTET_OUT == $past(gen_i[7:0])) && (FRAMER_OUT == $past(SAMPLE_IN));
  endproperty
  a_scr_point: assert property (p_scr_point) else $error("scrambler insert wrong");

  property p_toggle;
    (mode == SLT_TM_TOGGLE && ins_sel == SLT_INS_FRAMER)[*2] |=>
      FRAMER_OUT.i == ~$past(FRAMER_OUT.i);
  endproperty
  a_toggle: assert property (p_toggle) else $error("word toggle not alternating");

  property p_user_rep;
    (mode == SLT_TM_USER_REP && ins_sel == SLT_INS_FRAMER) |=>
      FRAMER_OUT.i == $past(user_word);
  endproperty
  a_user_rep: assert property (p_user_rep) else $error("user word not repeated");

  property p_ramp_q;
    (mode == SLT_TM_RAMP && ins_sel == SLT_INS_FRAMER && SINGLE_LANE) |=>
      FRAMER_OUT.q == FRAMER_OUT.i - 16'h0001;
  endproperty
  a_ramp_q: assert property (p_ramp_q) else $error("ramp Q not I minus one");

  property p_ilas_count;
    $fell(ILAS_ACTIVE) && !$past(s.sync_asserted) |->
      $past(s.ilas_cnt) == $past(s.regs.repeat_cnt);
  endproperty
  a_ilas_count: assert property (p_ilas_count) else $error("alignment count wrong");

  property p_sysref_pd;
    $rose(SYSREF_EVENT) |-> !$past(s.regs.sync_sysref[`SLT_SYSREF_PD_BIT]) && $past(SYSREF_IN);
  endproperty
  a_sysref_pd: assert property (p_sysref_pd) else $error("SYSREF seen while down");

  property p_ilas_start;
    $rose(ILAS_ACTIVE) |-> $past(LMFC_EDGE) && !$past(s.sync_asserted);
  endproperty
  a_ilas_start: assert property (p_ilas_start) else $error("alignment start off edge");

  property p_ilas_cont;
    ILAS_ACTIVE && align_mode == 2'b11 && !s.sync_asserted |=> ILAS_ACTIVE;
  endproperty
  a_ilas_cont: assert property (p_ilas_cont) else $error("continuous alignment stopped");

  property p_no_test;
    !RST && !test_on |=> FRAMER_OUT == $past(SAMPLE_IN) && OCTET_OUT == $past(OCTET_IN);
  endproperty
  a_no_test: assert property (p_no_test) else $error("data altered with test off");

  c_ilas_done: cover property ($fell(ILAS_ACTIVE) && !s.sync_asserted);
  c_pn_long:   cover property ((mode == SLT_TM_PN_LONG) [*4]);
  c_wb_write:  cover property (WB_ACK_O && WB_WE_I && reg_idx == `SLT_IDX_PAT_CTRL);

endmodule : slt_link_ctrl

// >>> test/slt_host_rx_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host receiver model: drives the sync request on the chosen receiver line
module slt_host_rx_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic request,
  input  wire logic active_high,
  input  wire logic use_diff,
  output logic      sync_cmos,
  output logic      sync_diff
);
  logic toggle;
  logic level;

  // Unused line wiggles each cycle, so listening to it cannot pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      toggle <= 1'b0;
    else
      toggle <= ~toggle;
  end

  // Request level follows the programmed polarity; a release starts alignment
  assign level     = active_high ? request : ~request;
  assign sync_cmos = use_diff ? toggle : level;
  assign sync_diff = use_diff ? level : toggle;
endmodule : slt_host_rx_model

// >>> test/slt_link_ctrl_tb.sv
`timescale 1ns/1ps
`include "slt_defines.svh"
module slt_link_ctrl_tb
  import slt_pkg::*;
;
  logic           clock, rst, wb_cyc, wb_stb, wb_we, ack, sysref, lmfc, single;
  logic           req, act_hi, use_diff, sync_cmos, sync_diff, ilas_d;
  logic           sync_on, diff_sel, sysref_pd, sysref_ev, ilas;
  logic [11:0]    adr;
  logic [3:0]     sel;
  logic [31:0]    wdat, rdat, got;
  logic [7:0]     octet_in, octet_out;
  logic [9:0]     symbol_in, symbol_out;
  logic [15:0]    prev;
  slt_sample_type sample_in, framer_out;
  int             error_cnt, checks, lmfc_ph, lm_cnt, hi_cnt, rise_lm, user_cnt;
  int             base_lm, base_hi, base_u;

  slt_link_ctrl dut (.CLOCK(clock), .RST(rst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SYNC_REQ_CMOS(sync_cmos), .SYNC_REQ_DIFF(sync_diff),
    .SYSREF_IN(sysref), .LMFC_EDGE(lmfc), .SINGLE_LANE(single), .SAMPLE_IN(sample_in),
    .OCTET_IN(octet_in), .SYMBOL_IN(symbol_in), .FRAMER_OUT(framer_out),
    .OCTET_OUT(octet_out), .SYMBOL_OUT(symbol_out), .SYNC_ASSERTED(sync_on),
    .SYNC_DIFF_SELECT(diff_sel), .SYSREF_RX_POWERDOWN(sysref_pd),
    .SYSREF_EVENT(sysref_ev), .ILAS_ACTIVE(ilas));

  slt_host_rx_model host (.clock(clock), .rst(rst), .request(req), .active_high(act_hi),
    .use_diff(use_diff), .sync_cmos(sync_cmos), .sync_diff(sync_diff));

  // ==========================================================================
  // Clock, multiframe pulses and monitors
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Multiframe pulse every eight cycles; counters are only read as differences
  always @(posedge clock) begin
    lmfc_ph <= (lmfc_ph + 1) % 8;
    lmfc    <= (lmfc_ph == 6);
    ilas_d  <= ilas;
    if (lmfc && !sync_on)
      lm_cnt <= lm_cnt + 1;
    if (ilas)
      hi_cnt <= hi_cnt + 1;
    if (ilas && !ilas_d)
      rise_lm <= lm_cnt;
    if (framer_out.i === 16'h1234)
      user_cnt <= user_cnt + 1;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask : ticks

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    adr    <= {idx, 2'b00};
    wdat   <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      check(1'b0, 1'b1, "bus timeout");
    got = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(got, {24'h000000, exp}, "register read");
  endtask : rd

  // Hold the request, then release it just after a multiframe pulse
  task automatic release_sync();
    req <= 1'b1;
    ticks(12);
    do @(posedge clock); while (lmfc !== 1'b1);
    base_lm = lm_cnt;
    base_hi = hi_cnt;
    req <= 1'b0;
  endtask : release_sync

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short; the full sequence needs well under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, sysref} = 5'h10;
    {adr, wdat, sel, single} = {12'h000, 32'h00000000, 4'hF, 1'b1};
    {req, act_hi, use_diff} = 3'h4;
    error_cnt = 0;
    checks    = 0;
    sample_in = 32'h0F0F0F0F;
    octet_in  = 8'h3C;
    symbol_in = 10'h2C5;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // Reset values, read back, unmapped place
    rd(`SLT_IDX_PIN_POL, 8'h00);
    rd(`SLT_IDX_PAT_CTRL, 8'h00);
    rd(`SLT_IDX_REPEAT, 8'h00);
    rd(`SLT_IDX_SYNC_SYSREF, 8'h00);
    rd(`SLT_IDX_ALIGN_CTRL, 8'h04);
    wr(`SLT_IDX_REPEAT, 8'hA5);
    rd(`SLT_IDX_REPEAT, 8'hA5);
    wr(10'h000, 8'hFF);
    rd(10'h000, 8'h00);
    // Both polarities on both receivers, two cycles each level
    for (int k = 0; k < 4; k++) begin
      wr(`SLT_IDX_PIN_POL, k[0] ? 8'h20 : 8'h00);
      wr(`SLT_IDX_SYNC_SYSREF, k[1] ? 8'h04 : 8'h00);
      act_hi   <= k[0];
      use_diff <= k[1];
      for (int a = 0; a < 2; a++) begin
        req <= a[0];
        ticks(3);
        check(sync_on, a[0], "sync decode");
        ticks(1);
        check(sync_on, a[0], "sync decode");
      end
      check(diff_sel, k[1], "receiver select");
    end
    // SYSREF seen only while its receiver is powered
    for (int p = 0; p < 2; p++) begin
      wr(`SLT_IDX_SYNC_SYSREF, p[0] ? 8'h0C : 8'h04);
      check(sysref_pd, p[0], "powerdown out");
      sysref <= 1'b1;
      @(posedge clock);
      sysref <= 1'b0;
      #1 check(sysref_ev, p == 0, "sysref event");
    end
    // Symbol inversion, other stages untouched
    wr(`SLT_IDX_PIN_POL, 8'h22);
    ticks(1);
    #1 check(symbol_out, 10'h13A, "inverted symbol");
    check(framer_out, 32'h0F0F0F0F, "framer pass");
    check(octet_out, 8'h3C, "octet pass");
    wr(`SLT_IDX_PIN_POL, 8'h20);
    ticks(1);
    #1 check(symbol_out, 10'h2C5, "plain symbol");
    // User word at each insertion point
    wr(`SLT_IDX_USER_LO, 8'h34);
    wr(`SLT_IDX_USER_HI, 8'h12);
    // Select code 11 is the no-substitution case
    for (int s = 0; s < 4; s++) begin
      wr(`SLT_IDX_PAT_CTRL, {2'b00, s[1:0], 4'h5});
      ticks(1);
      #1 check(framer_out.i, s == 0 ? 16'h1234 : 16'h0F0F, "framer point");
      check(symbol_out, s == 1 ? 10'h234 : 10'h2C5, "phy point");
      check(octet_out, s == 2 ? 8'h34 : 8'h3C, "scrambler point");
    end
    // Single word once, repeating word every cycle
    wr(`SLT_IDX_PAT_CTRL, 8'h00);
    base_u = user_cnt;
    wr(`SLT_IDX_PAT_CTRL, 8'h06);
    ticks(8);
    check(user_cnt - base_u, 1, "single word count");
    wr(`SLT_IDX_PAT_CTRL, 8'h05);
    ticks(1);
    base_u = user_cnt;
    ticks(8);
    check(user_cnt - base_u, 8, "repeat word count");
    // Mode codes 0 to 11; stepping of checkerboard, toggle and ramp
    for (int m = 0; m < 12; m++) begin
      wr(`SLT_IDX_PAT_CTRL, m[7:0]);
      ticks(2);
      #1 prev = framer_out.i;
      check(prev !== 16'h0F0F, m != 0 && m != 9, "substitution");
      if (m == 1 || m == 2 || m == 7) begin
        @(posedge clock);
        #1 check(framer_out.i, {m == 7 ? prev + 16'h0001 : ~prev}, "pattern step");
      end
      // Q trails I only in single-lane use
      if (m == 7) begin
        check(framer_out.q, {framer_out.i - 16'h0001}, "ramp quadrature");
        single <= 1'b0;
        @(posedge clock);
        #1 check(framer_out.q, framer_out.i, "ramp dual lane");
        single <= 1'b1;
      end
    end
    wr(`SLT_IDX_PAT_CTRL, 8'h00);
    // Start delay and repeat count, shortest and longer case
    for (int t = 0; t < 2; t++) begin
      wr(`SLT_IDX_REPEAT, t ? 8'h02 : 8'h00);
      wr(`SLT_IDX_ALIGN_CTRL, t ? 8'h24 : 8'h04);
      release_sync();
      ticks(8 * (3 * t + 4));
      check(rise_lm - base_lm, 2 * t + 1, "start delay");
      check(hi_cnt - base_hi, 8 * (2 * t + 1), "alignment length");
    end
    // Continuous alignment stops only on a new request; mode 00 sends none
    wr(`SLT_IDX_ALIGN_CTRL, 8'h0C);
    release_sync();
    ticks(200);
    check(ilas, 1'b1, "continuous alignment");
    req <= 1'b1;
    ticks(3);
    check(ilas, 1'b0, "alignment stopped");
    wr(`SLT_IDX_ALIGN_CTRL, 8'h00);
    release_sync();
    ticks(40);
    check(hi_cnt - base_hi, 0, "alignment disabled");
    tally_and_finish();
  end
endmodule : slt_link_ctrl_tb
